// ---- design/rcr_params.svh ----
// Purpose: constants of the radio control, event and calibration bank.
// Assumes: byte-wide registers on a 10-bit address, one 10 MHz clock.
// Notes: Operation list follows.
// Operation
// - Aux clock tick every divisor cycles; zero stops.
// - Gain tick every sixteen times divisor cycles.
// - Radio flag 7 on wake count reaching limit.
// - Radio flag 6 on listen strength over limit, listen active.
// - Radio flag 5 on cipher done, module loaded.
// - Radio flag 4 on transmit end, packet mode.
// - Flags 3,2 address match, checksum, packet mode.
// - Radio flag 1 on qualified sync word.
// - Radio flag 0 on qualified preamble.
// - System flag 7 when supply below limit.
// - System flag 6 when command processor ready.
// - System flag 4 on wake timeout; 5,3,2 unused.
// - System flag 1 port ready; 0 command finished.
// - Control bit 1 enables synthesizer calibration.
// - Control bit 0 enables filter calibration.
// - Status bit 1 set when synthesizer calibrated.
// - Status bit 0 set when filter calibrated.
// - Calibrated filter word readable, valid after cycle.
// - Override bit 0 substitutes forced filter word.
// - Reference code selects 1.85/1.95/1.75/1.65 V.
`ifndef RCR_PARAMS_SVH
`define RCR_PARAMS_SVH
`define RCR_ADDR_AUX_DIV 10'h32E
`define RCR_ADDR_GAIN_DIV 10'h32F
`define RCR_ADDR_FLG_RADIO 10'h336
`define RCR_ADDR_FLG_SYS 10'h337
`define RCR_ADDR_CAL_EN 10'h338
`define RCR_ADDR_CAL_ST 10'h339
`define RCR_ADDR_WORD_RB 10'h345
`define RCR_ADDR_WORD_OVR 10'h346
`define RCR_ADDR_CONV_LOW 10'h359
`define RCR_RST_AUX_DIV 8'h04
`define RCR_RST_GAIN_DIV 8'h28
`define RCR_GAIN_PRESCALE 4'hF
`define RCR_FLG_SYS_USED 8'hD3
`define RCR_BIT_SYNTH_EN 1
`define RCR_BIT_FILT_EN 0
`define RCR_BIT_FORCE_EN 0
`define RCR_REF_MV_0 11'h73A
`define RCR_REF_MV_1 11'h79E
`define RCR_REF_MV_2 11'h6D6
`define RCR_REF_MV_3 11'h672
`define RCR_MCLK_NS 100
`define RCR_SYNTH_CAL_NS 50000
`define RCR_FILT_CAL_NS 10000
`define RCR_SYNTH_CAL_CYC ((`RCR_SYNTH_CAL_NS + `RCR_MCLK_NS - 1) / `RCR_MCLK_NS)
`define RCR_FILT_CAL_CYC ((`RCR_FILT_CAL_NS + `RCR_MCLK_NS - 1) / `RCR_MCLK_NS)
`endif

// ---- design/rcr_pkg.sv ----
// Purpose: types of the radio control, event and calibration bank.
// Assumes: rcr_params.svh holds the numbers.
// Notes: state of the bank is one packed struct.
package rcr_pkg;
	typedef enum logic [2:0] {
		RCR_FILT_IDLE = 3'h1,
		RCR_FILT_RUN = 3'h2,
		RCR_FILT_DONE = 3'h4
	} rcr_filt_e;
	typedef struct packed {
		logic wake_event;
		logic cipher_done;
		logic tx_end;
		logic addr_match;
		logic crc_good;
		logic sync_found;
		logic preamble_found;
	} rcr_radio_ev_s;
	typedef struct packed {
		logic cmd_ready;
		logic wake_timeout;
		logic spi_ready;
		logic cmd_done;
	} rcr_sys_ev_s;
	typedef struct packed {
		logic [7:0] aux_div;
		logic [7:0] gain_div;
		logic [7:0] flg_radio;
		logic [7:0] flg_sys;
		logic [7:0] cal_en;
		logic synth_done;
		logic filt_done;
		logic ramp_done;
		logic [5:0] cal_word;
		logic [7:0] word_ovr;
		logic [7:0] conv_low;
		logic [15:0] wake_cnt;
		logic [3:0] aux_cnt;
		logic [3:0] pre_cnt;
		logic [7:0] gain_cnt;
		logic [9:0] synth_cnt;
		logic [9:0] filt_cnt;
		rcr_filt_e filt_state;
		logic [7:0] rdata;
		logic rd_valid;
		logic aux_tick;
		logic gain_tick;
		logic [5:0] word_used;
		logic [10:0] ref_mv;
	} rcr_st_s;
endpackage

// ---- design/rcr_regs.sv ----
// Purpose: register bank for clock dividers, event flags and calibration.
// Assumes: host port is synchronous to i_mclk; event inputs are pulses.
// Notes: reads answer one cycle later; flags clear on writing one.
`timescale 1ns/100ps
`include "rcr_params.svh"
module rcr_regs
	import rcr_pkg::*;
#(
	parameter int SYNTH_CAL_CYC = `RCR_SYNTH_CAL_CYC,
	parameter int FILT_CAL_CYC = `RCR_FILT_CAL_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [9:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire rcr_radio_ev_s i_radio_ev,
	input wire rcr_sys_ev_s i_sys_ev,
	input wire logic i_packet_mode,
	input wire logic i_cipher_loaded,
	input wire logic [15:0] i_wake_count_limit,
	input wire logic i_listen_active,
	input wire logic [7:0] i_listen_strength,
	input wire logic [7:0] i_listen_limit,
	input wire logic [4:0] i_supply_code,
	input wire logic [4:0] i_supply_limit,
	input wire logic [5:0] i_filter_cal_result,
	input wire logic i_amp_ramp_done,
	output logic [7:0] o_rdata,
	output logic o_rd_valid,
	output logic o_aux_tick,
	output logic o_gain_tick,
	output logic o_synth_calib_enable,
	output logic o_filter_calib_enable,
	output logic [5:0] o_filter_cal_word,
	output logic [1:0] o_converter_channel_select,
	output logic [1:0] o_converter_ref_code,
	output logic [10:0] o_converter_ref_mv
);

	localparam logic [9:0] SYNTH_LAST = 10'(SYNTH_CAL_CYC - 1);
	localparam logic [9:0] FILT_LAST = 10'(FILT_CAL_CYC - 1);

	rcr_st_s st_reg;
	rcr_st_s st_next;

	logic wr_aux;
	logic wr_gain;
	logic wr_flg0;
	logic wr_flg1;
	logic wr_cal;
	logic wr_ovr;
	logic wr_conv;
	logic [7:0] ev_radio;
	logic [7:0] ev_sys;
	logic [15:0] wake_inc;
	logic [3:0] aux_div;

	assign wr_aux = i_wr_en && (i_addr == `RCR_ADDR_AUX_DIV);
	assign wr_gain = i_wr_en && (i_addr == `RCR_ADDR_GAIN_DIV);
	assign wr_flg0 = i_wr_en && (i_addr == `RCR_ADDR_FLG_RADIO);
	assign wr_flg1 = i_wr_en && (i_addr == `RCR_ADDR_FLG_SYS);
	assign wr_cal = i_wr_en && (i_addr == `RCR_ADDR_CAL_EN);
	assign wr_ovr = i_wr_en && (i_addr == `RCR_ADDR_WORD_OVR);
	assign wr_conv = i_wr_en && (i_addr == `RCR_ADDR_CONV_LOW);
	assign wake_inc = st_reg.wake_cnt + 16'h0001;
	assign aux_div = st_reg.aux_div[3:0];

	// Radio event sources
	always_comb begin
		ev_radio = 8'h00;
		ev_radio[7] = i_radio_ev.wake_event && (wake_inc == i_wake_count_limit);
		ev_radio[6] = i_listen_active && (i_listen_strength > i_listen_limit);
		ev_radio[5] = i_cipher_loaded && i_radio_ev.cipher_done;
		ev_radio[4] = i_packet_mode && i_radio_ev.tx_end;
		ev_radio[3] = i_packet_mode && i_radio_ev.addr_match;
		ev_radio[2] = i_packet_mode && i_radio_ev.crc_good;
		ev_radio[1] = i_radio_ev.sync_found;
		ev_radio[0] = i_radio_ev.preamble_found;
	end

	// System event sources; unused positions stay zero
	always_comb begin
		ev_sys = 8'h00;
		ev_sys[7] = i_supply_code < i_supply_limit;
		ev_sys[6] = i_sys_ev.cmd_ready;
		ev_sys[4] = i_sys_ev.wake_timeout;
		ev_sys[1] = i_sys_ev.spi_ready;
		ev_sys[0] = i_sys_ev.cmd_done;
	end

	always_comb begin
		st_next = st_reg;
		st_next.aux_tick = 1'b0;
		st_next.gain_tick = 1'b0;
		st_next.rd_valid = 1'b0;

		if (wr_aux) begin
			st_next.aux_div = i_wdata;
		end
		if (wr_gain) begin
			st_next.gain_div = i_wdata;
		end
		if (wr_ovr) begin
			st_next.word_ovr = i_wdata;
		end
		if (wr_conv) begin
			st_next.conv_low = i_wdata;
		end

		// Set wins over a clear landing in the same cycle
		if (wr_flg0) begin
			st_next.flg_radio = st_reg.flg_radio & ~i_wdata;
		end
		st_next.flg_radio = st_next.flg_radio | ev_radio;
		if (wr_flg1) begin
			st_next.flg_sys = st_reg.flg_sys & ~i_wdata;
		end
		st_next.flg_sys = (st_next.flg_sys | ev_sys) & `RCR_FLG_SYS_USED;

		// Wake counter wraps; the flag fires only on the reaching step
		if (i_radio_ev.wake_event) begin
			st_next.wake_cnt = wake_inc;
		end

		// Aux divider: one tick per divisor cycles
		if (aux_div == 4'h0) begin
			st_next.aux_cnt = 4'h0;
		end else if (st_reg.aux_cnt >= aux_div - 4'h1) begin
			st_next.aux_cnt = 4'h0;
			st_next.aux_tick = 1'b1;
		end else begin
			st_next.aux_cnt = st_reg.aux_cnt + 4'h1;
		end

		// Gain divider: prescale by sixteen, then by the field
		if (st_reg.gain_div == 8'h00) begin
			st_next.pre_cnt = 4'h0;
			st_next.gain_cnt = 8'h00;
		end else if (st_reg.pre_cnt == `RCR_GAIN_PRESCALE) begin
			st_next.pre_cnt = 4'h0;
			if (st_reg.gain_cnt >= st_reg.gain_div - 8'h01) begin
				st_next.gain_cnt = 8'h00;
				st_next.gain_tick = 1'b1;
			end else begin
				st_next.gain_cnt = st_reg.gain_cnt + 8'h01;
			end
		end else begin
			st_next.pre_cnt = st_reg.pre_cnt + 4'h1;
		end

		// Calibration enables; a fresh enable restarts the synthesizer
		if (wr_cal) begin
			st_next.cal_en = i_wdata;
			if (i_wdata[`RCR_BIT_SYNTH_EN] && !st_reg.cal_en[`RCR_BIT_SYNTH_EN]) begin
				st_next.synth_done = 1'b0;
				st_next.synth_cnt = 10'h000;
			end
		end

		// Synthesizer calibration only advances while enabled
		if (!st_reg.cal_en[`RCR_BIT_SYNTH_EN]) begin
			st_next.synth_cnt = 10'h000;
		end else if (!st_reg.synth_done && !(wr_cal && !i_wdata[`RCR_BIT_SYNTH_EN])) begin
			if (st_reg.synth_cnt == SYNTH_LAST) begin
				st_next.synth_done = 1'b1;
			end else begin
				st_next.synth_cnt = st_reg.synth_cnt + 10'h001;
			end
		end

		// Filter calibration sequence
		case (st_reg.filt_state)
			RCR_FILT_IDLE: begin
				if (st_reg.cal_en[`RCR_BIT_FILT_EN]) begin
					st_next.filt_state = RCR_FILT_RUN;
					st_next.filt_cnt = 10'h000;
					st_next.filt_done = 1'b0;
				end
			end
			RCR_FILT_RUN: begin
				if (!st_reg.cal_en[`RCR_BIT_FILT_EN]) begin
					st_next.filt_state = RCR_FILT_IDLE;
				end else if (st_reg.filt_cnt == FILT_LAST) begin
					st_next.filt_state = RCR_FILT_DONE;
					st_next.filt_done = 1'b1;
					st_next.cal_word = i_filter_cal_result;
				end else begin
					st_next.filt_cnt = st_reg.filt_cnt + 10'h001;
				end
			end
			RCR_FILT_DONE: begin
				if (!st_reg.cal_en[`RCR_BIT_FILT_EN]) begin
					st_next.filt_state = RCR_FILT_IDLE;
				end
			end
			default: begin
				st_next.filt_state = RCR_FILT_IDLE;
			end
		endcase

		st_next.ramp_done = i_amp_ramp_done;

		// Override replaces the calibrated word downstream
		if (st_reg.word_ovr[`RCR_BIT_FORCE_EN]) begin
			st_next.word_used = st_reg.word_ovr[6:1];
		end else begin
			st_next.word_used = st_reg.cal_word;
		end

		// Reference in millivolts, quoted for a 3 V supply
		case (st_reg.conv_low[1:0])
			2'h0: st_next.ref_mv = `RCR_REF_MV_0;
			2'h1: st_next.ref_mv = `RCR_REF_MV_1;
			2'h2: st_next.ref_mv = `RCR_REF_MV_2;
			default: st_next.ref_mv = `RCR_REF_MV_3;
		endcase

		// Read mux; unmapped addresses return zero
		if (i_rd_en) begin
			st_next.rd_valid = 1'b1;
			case (i_addr)
				`RCR_ADDR_AUX_DIV: st_next.rdata = st_reg.aux_div;
				`RCR_ADDR_GAIN_DIV: st_next.rdata = st_reg.gain_div;
				`RCR_ADDR_FLG_RADIO: st_next.rdata = st_reg.flg_radio;
				`RCR_ADDR_FLG_SYS: st_next.rdata = st_reg.flg_sys;
				`RCR_ADDR_CAL_EN: st_next.rdata = st_reg.cal_en;
				`RCR_ADDR_CAL_ST: begin
					st_next.rdata = {5'h00, st_reg.ramp_done, st_reg.synth_done,
						st_reg.filt_done};
				end
				`RCR_ADDR_WORD_RB: st_next.rdata = {2'h0, st_reg.cal_word};
				`RCR_ADDR_WORD_OVR: st_next.rdata = st_reg.word_ovr;
				`RCR_ADDR_CONV_LOW: st_next.rdata = st_reg.conv_low;
				default: st_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st_reg <= '0;
			st_reg.aux_div <= `RCR_RST_AUX_DIV;
			st_reg.gain_div <= `RCR_RST_GAIN_DIV;
			st_reg.filt_state <= RCR_FILT_IDLE;
			st_reg.ref_mv <= `RCR_REF_MV_0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_rdata = st_reg.rdata;
	assign o_rd_valid = st_reg.rd_valid;
	assign o_aux_tick = st_reg.aux_tick;
	assign o_gain_tick = st_reg.gain_tick;
	assign o_synth_calib_enable = st_reg.cal_en[`RCR_BIT_SYNTH_EN];
	assign o_filter_calib_enable = st_reg.cal_en[`RCR_BIT_FILT_EN];
	assign o_filter_cal_word = st_reg.word_used;
	assign o_converter_channel_select = st_reg.conv_low[3:2];
	assign o_converter_ref_code = st_reg.conv_low[1:0];
	assign o_converter_ref_mv = st_reg.ref_mv;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	chk_aux_off: assert property (
		o_aux_tick |-> $past(st_reg.aux_div[3:0]) != 4'h0)
		else $error("aux tick while divisor zero");
	chk_aux_gap: assert property (
		(o_aux_tick && st_reg.aux_div[3:0] > 4'h1 && !wr_aux) |=> !o_aux_tick)
		else $error("aux ticks too close");
	chk_gain_gap: assert property (
		o_gain_tick |=> !o_gain_tick [*8])
		else $error("gain ticks too close");
	chk_flag_sticky: assert property (
		!wr_flg0 |=> (st_reg.flg_radio & $past(st_reg.flg_radio)) == $past(st_reg.flg_radio))
		else $error("radio flag lost without clear");
	chk_tx_gate: assert property (
		(!i_packet_mode && !st_reg.flg_radio[4]) |=> !st_reg.flg_radio[4])
		else $error("transmit flag outside packet mode");
	chk_crc_set: assert property (
		(i_packet_mode && i_radio_ev.crc_good) |=> st_reg.flg_radio[2])
		else $error("checksum flag missed");
	chk_sync_set: assert property (
		i_radio_ev.sync_found |=> st_reg.flg_radio[1] [*1])
		else $error("sync flag missed");
	chk_sys_unused: assert property (
		(st_reg.flg_sys & ~`RCR_FLG_SYS_USED) == 8'h00)
		else $error("unused system flag set");
	chk_filt_busy: assert property (
		(st_reg.filt_state == RCR_FILT_RUN) |-> !st_reg.filt_done)
		else $error("filter done while running");
	chk_word_force: assert property (
		st_reg.word_ovr[0] |=> o_filter_cal_word == $past(st_reg.word_ovr[6:1]))
		else $error("forced word not applied");
	chk_ref_code: assert property (
		(st_reg.conv_low[1:0] == 2'h0) |=> o_converter_ref_mv == `RCR_REF_MV_0)
		else $error("reference code zero wrong");
	chk_read_ans: assert property (
		i_rd_en |=> o_rd_valid)
		else $error("read not answered");
	chk_rd_quiet: assert property (
		!i_rd_en |=> !o_rd_valid)
		else $error("read answer without request");
	chk_aux_zero: assert property (
		(st_reg.aux_div[3:0] == 4'h0) |=> !o_aux_tick)
		else $error("aux tick with divisor zero");
	chk_wake_count: assert property (
		i_radio_ev.wake_event |=> st_reg.wake_cnt == $past(st_reg.wake_cnt) + 16'h0001)
		else $error("wake counter missed a step");
	chk_wake_set: assert property (
		(i_radio_ev.wake_event && wake_inc == i_wake_count_limit) |=> st_reg.flg_radio[7])
		else $error("wake count flag missed");
	chk_listen_set: assert property (
		(i_listen_active && i_listen_strength > i_listen_limit) |=> st_reg.flg_radio[6])
		else $error("listen strength flag missed");
	chk_cipher_set: assert property (
		(i_cipher_loaded && i_radio_ev.cipher_done) |=> st_reg.flg_radio[5])
		else $error("cipher flag missed");
	chk_cipher_gate: assert property (
		(!i_cipher_loaded && !st_reg.flg_radio[5]) |=> !st_reg.flg_radio[5])
		else $error("cipher flag without module");
	chk_tx_set: assert property (
		(i_packet_mode && i_radio_ev.tx_end) |=> st_reg.flg_radio[4])
		else $error("transmit flag missed");
	chk_addr_set: assert property (
		(i_packet_mode && i_radio_ev.addr_match) |=> st_reg.flg_radio[3])
		else $error("address flag missed");
	chk_preamble_set: assert property (
		i_radio_ev.preamble_found |=> st_reg.flg_radio[0])
		else $error("preamble flag missed");
	chk_supply_set: assert property (
		(i_supply_code < i_supply_limit) |=> st_reg.flg_sys[7])
		else $error("supply flag missed");
	chk_ready_set: assert property (
		i_sys_ev.cmd_ready |=> st_reg.flg_sys[6])
		else $error("command ready flag missed");
	chk_timeout_set: assert property (
		i_sys_ev.wake_timeout |=> st_reg.flg_sys[4])
		else $error("wake timeout flag missed");
	chk_port_set: assert property (
		i_sys_ev.spi_ready |=> st_reg.flg_sys[1])
		else $error("port ready flag missed");
	chk_done_set: assert property (
		i_sys_ev.cmd_done |=> st_reg.flg_sys[0])
		else $error("command done flag missed");
	chk_flag_clear: assert property (
		(wr_flg0 && ev_radio == 8'h00) |=> (st_reg.flg_radio & $past(i_wdata)) == 8'h00)
		else $error("radio flag not cleared");
	chk_synth_en: assert property (
		wr_cal |=> o_synth_calib_enable == $past(i_wdata[`RCR_BIT_SYNTH_EN]))
		else $error("synthesizer enable not applied");
	chk_filt_en: assert property (
		wr_cal |=> o_filter_calib_enable == $past(i_wdata[`RCR_BIT_FILT_EN]))
		else $error("filter enable not applied");
	chk_synth_rise: assert property (
		$rose(st_reg.synth_done) |-> $past(st_reg.cal_en[`RCR_BIT_SYNTH_EN]))
		else $error("synthesizer done while disabled");
	chk_word_hold: assert property (
		(st_reg.filt_state != RCR_FILT_RUN) |=> st_reg.cal_word == $past(st_reg.cal_word))
		else $error("calibrated word changed outside run");
	chk_word_cal: assert property (
		!st_reg.word_ovr[0] |=> o_filter_cal_word == $past(st_reg.cal_word))
		else $error("calibrated word not applied");

	cov_aux_tick: cover property (o_aux_tick ##[1:20] o_aux_tick);
	cov_filt_done: cover property ($rose(st_reg.filt_done));
	cov_set_clear: cover property (wr_flg0 && (ev_radio & i_wdata) != 8'h00);
	cov_synth_done: cover property ($rose(st_reg.synth_done));
	cov_wake_reach: cover property (i_radio_ev.wake_event && ev_radio[7]);

endmodule

// ---- tb/rcr_host.sv ----
// Purpose: host model on the register port of the bank.
// Assumes: one request at a time, launched just after a rising edge.
// Notes: released address and data show the inverse of the last value.
`timescale 1ns/100ps
module rcr_host (
	input wire logic i_mclk,
	input wire logic [7:0] i_rdata,
	input wire logic i_rd_valid,
	output logic o_wr_en,
	output logic o_rd_en,
	output logic [9:0] o_addr,
	output logic [7:0] o_wdata
);
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 10'h000;
		o_wdata = 8'h00;
	end
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		o_wr_en <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_mclk);
		o_wr_en <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	task automatic rd(input logic [9:0] a, output logic [7:0] d, output bit ok);
		@(posedge i_mclk);
		o_rd_en <= 1'b1;
		o_addr <= a;
		@(posedge i_mclk);
		o_rd_en <= 1'b0;
		o_addr <= ~a;
		#1;
		// Answer is registered at the taking edge and sampled 1 ns after it
		ok = (i_rd_valid === 1'b1);
		d = i_rdata;
	endtask
endmodule

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the radio control register bank.
// Assumes: short calibration counts of 4 and 3 cycles.
// Notes: every scenario task judges its own results.
`timescale 1ns/100ps
`include "rcr_params.svh"
module testbench
	import rcr_pkg::*;
;
	logic mclk = 1'b0;
	logic rst, wr_en, rd_en, pmode, cload, lact, ramp, rd_valid, atick, gtick, sen, fen;
	logic [9:0] addr;
	logic [7:0] wdata, rdata, lstr, llim;
	rcr_radio_ev_s rev;
	rcr_sys_ev_s sev;
	logic [15:0] wlim;
	logic [4:0] scode, slim;
	logic [5:0] fres, fword;
	logic [1:0] csel, rcode;
	logic [10:0] rmv;
	int errors = 0;
	int n_checks = 0;
	logic [9:0] ra [10] = '{10'h32E, 10'h32F, 10'h336, 10'h337, 10'h338, 10'h339,
		10'h345, 10'h346, 10'h359, 10'h300};
	logic [7:0] rv [10] = '{8'h04, 8'h28, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00};
	logic [10:0] mvt [4] = '{11'h73A, 11'h79E, 11'h6D6, 11'h672};
	always #50 mclk = ~mclk;
	rcr_host rcr_host_inst (.i_mclk(mclk), .i_rdata(rdata), .i_rd_valid(rd_valid),
		.o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
	rcr_regs #(.SYNTH_CAL_CYC(4), .FILT_CAL_CYC(3)) rcr_regs_inst (.i_mclk(mclk),
		.i_rst(rst), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
		.i_radio_ev(rev), .i_sys_ev(sev), .i_packet_mode(pmode), .i_cipher_loaded(cload),
		.i_wake_count_limit(wlim), .i_listen_active(lact), .i_listen_strength(lstr),
		.i_listen_limit(llim), .i_supply_code(scode), .i_supply_limit(slim),
		.i_filter_cal_result(fres), .i_amp_ramp_done(ramp), .o_rdata(rdata),
		.o_rd_valid(rd_valid), .o_aux_tick(atick), .o_gain_tick(gtick),
		.o_synth_calib_enable(sen), .o_filter_calib_enable(fen), .o_filter_cal_word(fword),
		.o_converter_channel_select(csel), .o_converter_ref_code(rcode),
		.o_converter_ref_mv(rmv));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [9:0] a, input logic [7:0] e);
		logic [7:0] d;
		bit ok;
		rcr_host_inst.rd(a, d, ok);
		if (!ok) begin
			errors++;
			finish_test();
		end
		chk(16'(d), 16'(e));
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		rcr_host_inst.wr(a, d);
	endtask
	// First pass finds a tick, second measures the interval
	task automatic per(input bit g, input int n);
		int k;
		for (int j = 0; j < 2; j++) begin
			k = 0;
			do begin
				@(posedge mclk);
				#1;
				k++;
			end while ((g ? gtick : atick) !== 1'b1 && k < 700);
		end
		chk(16'(k), 16'(n));
		if (k >= 700) begin
			finish_test();
		end
	endtask
	task automatic pev(input rcr_radio_ev_s r, input rcr_sys_ev_s s);
		@(posedge mclk);
		rev <= r;
		sev <= s;
		@(posedge mclk);
		rev <= '0;
		sev <= '0;
	endtask
	task automatic t_reset();
		chk(16'(rmv), 16'h073A);
		for (int i = 0; i < 10; i++) begin
			rdc(ra[i], rv[i]);
		end
		$display("reset test done");
	endtask
	task automatic t_tick();
		int k;
		per(1'b0, 4);
		per(1'b1, 640);
		wr(`RCR_ADDR_AUX_DIV, 8'h01);
		per(1'b0, 1);
		wr(`RCR_ADDR_AUX_DIV, 8'hF3);
		per(1'b0, 3);
		rdc(`RCR_ADDR_AUX_DIV, 8'hF3);
		wr(`RCR_ADDR_GAIN_DIV, 8'h01);
		rdc(`RCR_ADDR_GAIN_DIV, 8'h01);
		per(1'b1, 16);
		wr(`RCR_ADDR_AUX_DIV, 8'h00);
		wr(`RCR_ADDR_GAIN_DIV, 8'h00);
		k = 0;
		repeat (40) begin
			@(posedge mclk);
			#1;
			k += int'(atick === 1'b1) + int'(gtick === 1'b1);
		end
		chk(16'(k), 16'h0000);
		$display("divider test done");
	endtask
	task automatic t_radio();
		pev(7'h3C, 4'h0);
		rdc(`RCR_ADDR_FLG_RADIO, 8'h00);
		@(posedge mclk);
		pmode <= 1'b1;
		cload <= 1'b1;
		for (int b = 0; b < 6; b++) begin
			pev(7'h01 << b, 4'h0);
			rdc(`RCR_ADDR_FLG_RADIO, 8'h01 << b);
			wr(`RCR_ADDR_FLG_RADIO, 8'h01 << b);
			rdc(`RCR_ADDR_FLG_RADIO, 8'h00);
		end
		// Event and clear taken at one edge: the set must win
		fork
			pev(7'h01, 4'h0);
			wr(`RCR_ADDR_FLG_RADIO, 8'h01);
		join
		rdc(`RCR_ADDR_FLG_RADIO, 8'h01);
		wr(`RCR_ADDR_FLG_RADIO, 8'h01);
		pev(7'h40, 4'h0);
		rdc(`RCR_ADDR_FLG_RADIO, 8'h00);
		pev(7'h40, 4'h0);
		rdc(`RCR_ADDR_FLG_RADIO, 8'h80);
		@(posedge mclk);
		lact <= 1'b1;
		@(posedge mclk);
		lact <= 1'b0;
		rdc(`RCR_ADDR_FLG_RADIO, 8'hC0);
		wr(`RCR_ADDR_FLG_RADIO, 8'hFF);
		rdc(`RCR_ADDR_FLG_RADIO, 8'h00);
		$display("radio flag test done");
	endtask
	task automatic t_sys();
		logic [7:0] e;
		e = 8'h00;
		wr(`RCR_ADDR_FLG_SYS, 8'h2C);
		rdc(`RCR_ADDR_FLG_SYS, 8'h00);
		for (int b = 0; b < 4; b++) begin
			pev(7'h00, 4'h1 << b);
			e = e | 8'(32'h40100201 >> (8 * b));
			rdc(`RCR_ADDR_FLG_SYS, e);
		end
		@(posedge mclk);
		scode <= 5'h03;
		@(posedge mclk);
		scode <= 5'h1F;
		rdc(`RCR_ADDR_FLG_SYS, 8'hD3);
		wr(`RCR_ADDR_FLG_SYS, 8'hFF);
		rdc(`RCR_ADDR_FLG_SYS, 8'h00);
		$display("system flag test done");
	endtask
	task automatic t_cal();
		@(posedge mclk);
		ramp <= 1'b1;
		wr(`RCR_ADDR_CAL_EN, 8'h03);
		#1;
		chk(16'({sen, fen}), 16'h0003);
		rdc(`RCR_ADDR_CAL_ST, 8'h04);
		repeat (11) @(posedge mclk);
		rdc(`RCR_ADDR_CAL_ST, 8'h07);
		wr(`RCR_ADDR_CAL_ST, 8'hF8);
		wr(`RCR_ADDR_WORD_RB, 8'hFF);
		rdc(`RCR_ADDR_CAL_ST, 8'h07);
		rdc(`RCR_ADDR_WORD_RB, {2'h0, fres});
		chk(16'(fword), 16'(fres));
		wr(`RCR_ADDR_WORD_OVR, 8'h2B);
		@(posedge mclk);
		#1;
		chk(16'(fword), 16'h0015);
		wr(`RCR_ADDR_WORD_OVR, 8'h2A);
		@(posedge mclk);
		#1;
		chk(16'(fword), 16'(fres));
		rdc(`RCR_ADDR_WORD_OVR, 8'h2A);
		wr(`RCR_ADDR_CAL_EN, 8'h00);
		#1;
		chk(16'({sen, fen}), 16'h0000);
		$display("calibration test done");
	endtask
	task automatic t_conv();
		for (int c = 0; c < 4; c++) begin
			wr(`RCR_ADDR_CONV_LOW, {4'h0, 2'(3 - c), 2'(c)});
			@(posedge mclk);
			#1;
			chk(16'(rmv), 16'(mvt[c]));
			chk(16'({csel, rcode}), 16'({2'(3 - c), 2'(c)}));
		end
		$display("converter test done");
	endtask
	initial begin
		rst = 1'b1;
		pmode = 1'b0;
		cload = 1'b0;
		lact = 1'b0;
		ramp = 1'b0;
		lstr = 8'h0A;
		llim = 8'h09;
		rev = '0;
		sev = '0;
		wlim = 16'h0002;
		scode = 5'h1F;
		slim = 5'h04;
		fres = 6'h2D;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		t_reset();
		t_tick();
		t_radio();
		t_sys();
		t_cal();
		t_conv();
		finish_test();
	end
endmodule
